// ### common/zsr_pkg.sv
// Shared constants and types of the zero sequence reclose control
package zsr_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned TICK_PERIOD_NS  = 1000000;
  localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DELAY_STEP_MS   = 5;
  localparam int unsigned DELAY_MAX_MS    = 1800000;
  localparam int unsigned DELAY_MAX_STEPS = DELAY_MAX_MS / DELAY_STEP_MS;
  localparam int unsigned DLY_W           = 19;
  localparam int unsigned CNT_W           = 21;
  localparam int unsigned GROUPS          = 8;
  localparam int unsigned GRP_W           = 3;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_GROUP    = 8'h04;
  localparam logic [7:0] ADR_STATUS   = 8'h08;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADR_IRQ_CLR  = 8'h10;
  localparam logic [7:0] ADR_IRQ_EN   = 8'h14;
  localparam logic [7:0] ADR_ELAPSED  = 8'h18;
  localparam logic [7:0] ADR_DELAY    = 8'h20;
  localparam logic [7:0] ADR_DLY_MASK = 8'he0;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_BLOCK_BIT = 4;
  localparam int unsigned CTRL_FALLOW    = 8;
  localparam int unsigned CTRL_FORCE_LSB = 12;
  localparam int unsigned STAT_COND_LSB  = 0;
  localparam int unsigned STAT_ACTIVE    = 4;
  localparam int unsigned STAT_CLOSE     = 5;
  localparam int unsigned STAT_PROT      = 6;
  localparam int unsigned STAT_BLOCKED   = 7;
  localparam int unsigned STAT_EN_IN     = 8;
  localparam int unsigned STAT_TRIP_IN   = 9;
  localparam int unsigned STAT_BLK_IN    = 10;
  localparam int unsigned IRQ_ACTIVE     = 0;
  localparam int unsigned IRQ_CLOSE      = 1;
  localparam int unsigned IRQ_CLEARED    = 2;
  localparam int unsigned IRQ_BLOCKED    = 3;
  localparam int unsigned IRQ_W          = 4;

  // ==========================================================
  // Enumerations
  typedef enum logic [2:0] {
    MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
  } zsr_mode_e;

  typedef enum logic [2:0] {
    FORCE_NORMAL, FORCE_BLOCK, FORCE_REQUESTED, FORCE_BREAKER_CLOSE_CMD_STATE,
    FORCE_CLOSED_BLOCKED
  } zsr_force_e;

  typedef enum logic [2:0] {
    COND_NORMAL, COND_REQUESTED, COND_BLOCKED, COND_ACTIVE,
    COND_BREAKER_CLOSE_CMD_STATE, COND_CLOSED_BLOCKED
  } zsr_cond_e;

  typedef enum logic [1:0] {
    ST_IDLE, ST_ACTIVE, ST_COUNT, ST_CLOSE
  } zsr_state_e;

  // ==========================================================
  // Reset values
  localparam logic [2:0]       MODE_RST  = 3'h0;
  localparam logic [2:0]       FORCE_RST = 3'h0;
  localparam logic [GRP_W-1:0] GROUP_RST = 3'h0;
  localparam logic [DLY_W-1:0] DELAY_RST = 19'h00000;

endpackage : zsr_pkg

// ### core/zsr_sync2.sv
// Two flip-flop synchroniser for asynchronous binary inputs
`timescale 1ns/1ps
module zsr_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;

  if (W < 1) begin : g_chk
    $error("zsr_sync2: W must be at least 1");
  end

  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : zsr_sync2

// ### core/zsr_tick_gen.sv
// Millisecond tick divider
`timescale 1ns/1ps
module zsr_tick_gen #(
  parameter int unsigned TICK_CYCLES = zsr_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // One-cycle enable pulse
  output logic      tick_o
);

  localparam int unsigned DW = $clog2(TICK_CYCLES + 1);
  logic [DW-1:0] div_reg;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("zsr_tick_gen: TICK_CYCLES must be at least 2");
  end

  // ==========================================================
  // Divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= '0;
      tick_o  <= 1'b0;
    end else if (div_reg == DW'(TICK_CYCLES - 1)) begin
      div_reg <= '0;
      tick_o  <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      tick_o  <= 1'b0;
    end
  end

endmodule : zsr_tick_gen

// ### core/zsr_reclose_top.sv
// Zero sequence reclose control with Wishbone register slave
`timescale 1ns/1ps
// Functional notes
// - Enable input low means disabled; no close command then unless forcing is allowed
// - A trip from the residual overvoltage function starts a sequence
// - With blocked input active after trip, close once delay elapses
// - Countdown follows blocked input; it must stay active whole delay
// - Delay setting 0 to 1800 s in 5 ms steps
// - Eight delay sets; group or block change acts while running
// - Static mode On, Blocked, Test, Test/Blocked, Off; default On
// - Permitted forcing overrides reported status with chosen value
// - Blocked output while disabled except in mode Off, active until clear, close after delay
// - Protection block output holds off reopening until fault clears
module zsr_reclose_top #(
  parameter int unsigned TICK_CYCLES = zsr_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Protection inputs
  input  wire logic        reclose_enable_i,
  input  wire logic        residual_overvoltage_trip_i,
  input  wire logic        residual_overvoltage_blocked_i,
  // Function outputs
  output logic             recl_blocked_o,
  output logic             recl_active_o,
  output logic             breaker_close_out_o,
  output logic             residual_protection_block_out_o,
  output logic             irq_o
);

  localparam int unsigned CNT_W = zsr_pkg::CNT_W;
  localparam int unsigned DLY_W = zsr_pkg::DLY_W;

  typedef struct packed {
    zsr_pkg::zsr_state_e                     st;
    logic [CNT_W-1:0]                        cnt;
    logic [2:0]                              node_operating_mode;
    logic                                    blk_cmd;
    logic                                    f_allow;
    logic [2:0]                              f_val;
    logic [zsr_pkg::GRP_W-1:0]               group;
    logic [zsr_pkg::GROUPS-1:0][DLY_W-1:0]   delay;
    logic [zsr_pkg::IRQ_W-1:0]               irq_stat;
    logic [zsr_pkg::IRQ_W-1:0]               irq_en;
    logic [2:0]                              cond;
    logic                                    ack;
    logic [31:0]                             dat;
    logic                                    active;
    logic                                    close;
    logic                                    prot;
    logic                                    blocked;
    logic                                    irq;
  } zsr_regs_s;

  zsr_regs_s        r_reg;
  zsr_regs_s        r_next;
  logic [2:0]       ins_s;
  logic             en_s;
  logic             trip_s;
  logic             blk_s;
  logic             tick;
  logic             run;
  logic             test;
  logic             fault_clr;
  logic [CNT_W-1:0] dly_ms;
  logic [31:0]      rd;
  logic [31:0]      wd;
  logic             wr;
  logic [zsr_pkg::IRQ_W-1:0] ev;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("zsr_reclose_top: TICK_CYCLES must be at least 2");
  end

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] to_ms(input logic [DLY_W-1:0] d);
    to_ms = CNT_W'(d) * CNT_W'(zsr_pkg::DELAY_STEP_MS);
  endfunction : to_ms

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction : merge

  // ==========================================================
  // Input capture and tick
  zsr_sync2 #(.W(3)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({reclose_enable_i, residual_overvoltage_trip_i,
               residual_overvoltage_blocked_i}),
    .sync_o  (ins_s)
  );
  assign en_s   = ins_s[2];
  assign trip_s = ins_s[1];
  assign blk_s  = ins_s[0];

  zsr_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    ev     = '0;
    // Mode and block command act at once, no restart needed
    run = en_s && !r_reg.blk_cmd && (r_reg.node_operating_mode == zsr_pkg::MODE_ON ||
          r_reg.node_operating_mode == zsr_pkg::MODE_TEST);
    test      = r_reg.node_operating_mode == zsr_pkg::MODE_TEST;
    fault_clr = !trip_s && !blk_s;
    dly_ms    = to_ms(r_reg.delay[r_reg.group]);

    case (r_reg.st)
      zsr_pkg::ST_IDLE: begin
        if (trip_s) r_next.st = zsr_pkg::ST_ACTIVE;
      end
      zsr_pkg::ST_ACTIVE: begin
        if (fault_clr) r_next.st = zsr_pkg::ST_IDLE;
        else if (blk_s) r_next.st = zsr_pkg::ST_COUNT;
      end
      zsr_pkg::ST_COUNT: begin
        if (fault_clr) r_next.st = zsr_pkg::ST_IDLE;
        else if (!blk_s) r_next.st = zsr_pkg::ST_ACTIVE;
        else if (r_reg.cnt >= dly_ms) r_next.st = zsr_pkg::ST_CLOSE;
        else if (tick) r_next.cnt = r_reg.cnt + 1'b1;
      end
      zsr_pkg::ST_CLOSE: begin
        if (fault_clr) r_next.st = zsr_pkg::ST_IDLE;
      end
      default: r_next.st = zsr_pkg::ST_IDLE;
    endcase
    if (!run) r_next.st = zsr_pkg::ST_IDLE;
    if (r_next.st != zsr_pkg::ST_COUNT) r_next.cnt = '0;

    // Outputs follow the new state; test mode keeps the breaker untouched
    r_next.active  = r_next.st != zsr_pkg::ST_IDLE;
    r_next.close   = r_next.st == zsr_pkg::ST_CLOSE && !test;
    r_next.prot    = (r_next.st == zsr_pkg::ST_COUNT ||
                      r_next.st == zsr_pkg::ST_CLOSE) && !test;
    r_next.blocked = r_reg.node_operating_mode != zsr_pkg::MODE_OFF && !run;
    case (r_next.st)
      zsr_pkg::ST_ACTIVE: r_next.cond = zsr_pkg::COND_ACTIVE;
      zsr_pkg::ST_COUNT:  r_next.cond = zsr_pkg::COND_REQUESTED;
      zsr_pkg::ST_CLOSE:  r_next.cond = trip_s ? zsr_pkg::COND_BREAKER_CLOSE_CMD_STATE
                                               : zsr_pkg::COND_CLOSED_BLOCKED;
      default: r_next.cond = r_next.blocked ? zsr_pkg::COND_BLOCKED : zsr_pkg::COND_NORMAL;
    endcase

    if (r_reg.f_allow) begin
      case (r_reg.f_val)
        zsr_pkg::FORCE_BLOCK: begin
          r_next.blocked = 1'b1;
          r_next.cond    = zsr_pkg::COND_BLOCKED;
        end
        zsr_pkg::FORCE_REQUESTED: begin
          r_next.active = 1'b1;
          r_next.cond   = zsr_pkg::COND_REQUESTED;
        end
        zsr_pkg::FORCE_BREAKER_CLOSE_CMD_STATE: begin
          r_next.active = 1'b1;
          r_next.close  = 1'b1;
          r_next.cond   = zsr_pkg::COND_BREAKER_CLOSE_CMD_STATE;
        end
        zsr_pkg::FORCE_CLOSED_BLOCKED: begin
          r_next.active = 1'b1;
          r_next.prot   = 1'b1;
          r_next.cond   = zsr_pkg::COND_CLOSED_BLOCKED;
        end
        default: ;
      endcase
    end

    // Events
    ev[zsr_pkg::IRQ_ACTIVE]  = r_next.active && !r_reg.active;
    ev[zsr_pkg::IRQ_CLOSE]   = r_next.close && !r_reg.close;
    ev[zsr_pkg::IRQ_CLEARED] = r_reg.st != zsr_pkg::ST_IDLE && r_next.st == zsr_pkg::ST_IDLE;
    ev[zsr_pkg::IRQ_BLOCKED] = r_next.blocked && !r_reg.blocked;

    // Register read mux
    rd = '0;
    case (wb_adr_i & 8'hfc)
      zsr_pkg::ADR_CTRL: begin
        rd[zsr_pkg::CTRL_MODE_LSB +: 3]  = r_reg.node_operating_mode;
        rd[zsr_pkg::CTRL_BLOCK_BIT]      = r_reg.blk_cmd;
        rd[zsr_pkg::CTRL_FALLOW]         = r_reg.f_allow;
        rd[zsr_pkg::CTRL_FORCE_LSB +: 3] = r_reg.f_val;
      end
      zsr_pkg::ADR_GROUP: rd[zsr_pkg::GRP_W-1:0] = r_reg.group;
      zsr_pkg::ADR_STATUS: begin
        rd[zsr_pkg::STAT_COND_LSB +: 3] = r_reg.cond;
        rd[zsr_pkg::STAT_ACTIVE]        = r_reg.active;
        rd[zsr_pkg::STAT_CLOSE]         = r_reg.close;
        rd[zsr_pkg::STAT_PROT]          = r_reg.prot;
        rd[zsr_pkg::STAT_BLOCKED]       = r_reg.blocked;
        rd[zsr_pkg::STAT_EN_IN]         = en_s;
        rd[zsr_pkg::STAT_TRIP_IN]       = trip_s;
        rd[zsr_pkg::STAT_BLK_IN]        = blk_s;
      end
      zsr_pkg::ADR_IRQ_STAT: rd[zsr_pkg::IRQ_W-1:0] = r_reg.irq_stat;
      zsr_pkg::ADR_IRQ_EN:   rd[zsr_pkg::IRQ_W-1:0] = r_reg.irq_en;
      zsr_pkg::ADR_ELAPSED:  rd[CNT_W-1:0] = r_reg.cnt;
      default: begin
        if ((wb_adr_i & zsr_pkg::ADR_DLY_MASK) == zsr_pkg::ADR_DELAY) begin
          rd[DLY_W-1:0] = r_reg.delay[wb_adr_i[4:2]];
        end
      end
    endcase

    // Wishbone: ack one cycle after request, write lands on the ack edge
    r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
    r_next.dat = r_next.ack && !wb_we_i ? rd : 32'h0000_0000;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && r_reg.ack;
    wd = merge(rd, wb_dat_i, wb_sel_i);
    if (wr) begin
      case (wb_adr_i & 8'hfc)
        zsr_pkg::ADR_CTRL: begin
          // Unknown mode codes are dropped
          if (wd[zsr_pkg::CTRL_MODE_LSB +: 3] <= zsr_pkg::MODE_OFF) begin
            r_next.node_operating_mode = wd[zsr_pkg::CTRL_MODE_LSB +: 3];
          end
          r_next.blk_cmd = wd[zsr_pkg::CTRL_BLOCK_BIT];
          r_next.f_allow = wd[zsr_pkg::CTRL_FALLOW];
          r_next.f_val   = wd[zsr_pkg::CTRL_FORCE_LSB +: 3];
        end
        zsr_pkg::ADR_GROUP: r_next.group = wd[zsr_pkg::GRP_W-1:0];
        zsr_pkg::ADR_IRQ_EN: r_next.irq_en = wd[zsr_pkg::IRQ_W-1:0];
        default: begin
          if ((wb_adr_i & zsr_pkg::ADR_DLY_MASK) == zsr_pkg::ADR_DELAY) begin
            // Out of range settings clamp to the longest delay
            r_next.delay[wb_adr_i[4:2]] = (wd > zsr_pkg::DELAY_MAX_STEPS) ?
              DLY_W'(zsr_pkg::DELAY_MAX_STEPS) : wd[DLY_W-1:0];
          end
        end
      endcase
    end
    // Set beats a clear in the same cycle
    r_next.irq_stat = r_reg.irq_stat & ~((wr && (wb_adr_i & 8'hfc) == zsr_pkg::ADR_IRQ_CLR) ?
                      wd[zsr_pkg::IRQ_W-1:0] : 4'h0);
    r_next.irq_stat = r_next.irq_stat | ev;
    r_next.irq      = |(r_next.irq_stat & r_next.irq_en);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg                     <= '0;
      r_reg.st                  <= zsr_pkg::ST_IDLE;
      r_reg.node_operating_mode <= zsr_pkg::MODE_RST;
      r_reg.f_val               <= zsr_pkg::FORCE_RST;
      r_reg.group               <= zsr_pkg::GROUP_RST;
      r_reg.delay               <= {zsr_pkg::GROUPS{zsr_pkg::DELAY_RST}};
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o                        = r_reg.dat;
  assign wb_ack_o                        = r_reg.ack;
  assign recl_blocked_o                  = r_reg.blocked;
  assign recl_active_o                   = r_reg.active;
  assign breaker_close_out_o             = r_reg.close;
  assign residual_protection_block_out_o = r_reg.prot;
  assign irq_o                           = r_reg.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_count_entry;
    r_reg.st == zsr_pkg::ST_ACTIVE && blk_s && trip_s && run;
  endsequence
  sequence s_count_hold;
    r_reg.st == zsr_pkg::ST_COUNT && blk_s && run && r_reg.cnt < dly_ms && tick;
  endsequence

  chk_close_needs_enable: assert property (
    !en_s && !r_reg.f_allow |=> !breaker_close_out_o)
    else $error("close raised while enable low");
  chk_trip_starts_seq: assert property (
    r_reg.st == zsr_pkg::ST_IDLE && trip_s && run |=> recl_active_o)
    else $error("trip did not start sequence");
  chk_close_after_count: assert property (
    $rose(r_reg.st == zsr_pkg::ST_CLOSE) |-> $past(r_reg.st) == zsr_pkg::ST_COUNT)
    else $error("close state entered without countdown");
  chk_blocked_drop_abort: assert property (
    r_reg.st == zsr_pkg::ST_COUNT && !blk_s |=> r_reg.st != zsr_pkg::ST_CLOSE && r_reg.cnt == '0)
    else $error("countdown survived blocked drop");
  chk_delay_expiry: assert property (
    r_reg.st == zsr_pkg::ST_COUNT && blk_s && trip_s && run && r_reg.cnt >= dly_ms
    |=> r_reg.st == zsr_pkg::ST_CLOSE)
    else $error("close missed at delay expiry");
  chk_group_no_restart: assert property (
    r_reg.st == zsr_pkg::ST_COUNT && $changed(r_reg.group) |-> r_reg.cnt >= $past(r_reg.cnt))
    else $error("group switch restarted countdown");
  chk_group_keeps_mode: assert property (
    $changed(r_reg.group) |-> $stable(r_reg.node_operating_mode))
    else $error("mode changed with group");
  chk_force_close_cmd: assert property (
    r_reg.f_allow && r_reg.f_val == zsr_pkg::FORCE_BREAKER_CLOSE_CMD_STATE
    |=> breaker_close_out_o && r_reg.cond == zsr_pkg::COND_BREAKER_CLOSE_CMD_STATE)
    else $error("forced close not shown");
  chk_blocked_when_off: assert property (
    !en_s && !r_reg.f_allow && r_reg.node_operating_mode == zsr_pkg::MODE_ON
    |=> recl_blocked_o && !recl_active_o)
    else $error("blocked output missing while disabled");
  chk_prot_block_hold: assert property (
    s_count_entry ##1 blk_s && run && !test |=> residual_protection_block_out_o)
    else $error("protection block not raised");
  chk_fault_clear_idle: assert property (
    r_reg.st != zsr_pkg::ST_IDLE && !trip_s && !blk_s && !r_reg.f_allow
    |=> !recl_active_o && !breaker_close_out_o && !residual_protection_block_out_o)
    else $error("outputs held after fault clear");
  chk_tick_counts: assert property (
    (s_count_hold and trip_s) |=> r_reg.cnt == $past(r_reg.cnt) + 1'b1)
    else $error("tick not counted");

endmodule : zsr_reclose_top

// ### dv/zsr_prot_model.sv
// Residual overvoltage protection model feeding the reclose block
`timescale 1ns/1ps
module zsr_prot_model (
  // Clock
  input  wire logic clk_i,
  // Bench commands
  input  wire logic fault_i,
  input  wire logic brk_open_i,
  // Protection levels
  output logic      trip_o,
  output logic      blocked_o
);
  // ==========================================================
  // Levels
  // Blocked only while the fault persists; a fault clear drops both
  always_ff @(posedge clk_i) begin
    trip_o    <= fault_i;
    blocked_o <= fault_i & brk_open_i;
  end
endmodule : zsr_prot_model

// ### dv/tb_top.sv
// Self-checking bench of the zero sequence reclose control
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Signals
  localparam int TICKS = 4;
  localparam logic [31:0] FEXP [5] = '{32'h0, 32'h80, 32'h10, 32'h30, 32'h50};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack, irq, trip, blk, blocked_o, active_o, close_o, prot_o;
  logic        en = 1'b0;
  logic        fault = 1'b0;
  logic        brk_open = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] seed = 32'h38;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc_cnt = 0;

  always #20 clk_i = ~clk_i;

  zsr_reclose_top #(.TICK_CYCLES(TICKS)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .reclose_enable_i(en),
    .residual_overvoltage_trip_i(trip), .residual_overvoltage_blocked_i(blk),
    .recl_blocked_o(blocked_o), .recl_active_o(active_o), .breaker_close_out_o(close_o),
    .residual_protection_block_out_o(prot_o), .irq_o(irq));
  zsr_prot_model u_prot (.clk_i(clk_i), .fault_i(fault), .brk_open_i(brk_open),
    .trip_o(trip), .blocked_o(blk));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic cmp_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] reg 0x%h expected 0x%h seen 0x%h", a, e, g);
    end
  endtask : cmp_rd

  task automatic chk(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cycles

  // Reads note their expectation; the watcher below compares at ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hffffffff);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    // No answer time assumed; only the bench timeout ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      cmp_rd(adr, exp_q.pop_front(), rdat & msk_q.pop_front());
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ==========================================================
  // Sequences
  task automatic run_seq(input int d);
    int n;
    fault <= 1'b1;
    cycles(5);
    chk("active", 1'b1, active_o);
    brk_open <= 1'b1;
    if (d > 0) begin
      cycles((d * 5 - 1) * TICKS);
      chk("early close", 1'b0, close_o);
      chk("prot block", 1'b1, prot_o);
    end
    n = 0;
    while (close_o !== 1'b1 && n < 3 * TICKS + 10) begin
      cycles(1);
      n++;
    end
    chk("close", 1'b1, close_o);
  endtask : run_seq

  task automatic clear_fault;
    fault    <= 1'b0;
    brk_open <= 1'b0;
    cycles(6);
    chk("active clr", 1'b0, active_o);
    chk("close clr", 1'b0, close_o);
    chk("prot clr", 1'b0, prot_o);
  endtask : clear_fault

  initial begin
    int d1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, zsr_pkg::ADR_CTRL, 32'h0);
    wb(1'b0, 8'h1c, 32'h0);
    wb(1'b1, zsr_pkg::ADR_DELAY, 32'h2);
    seed = xs(seed);
    d1 = int'(seed[1:0]) + 1;
    wb(1'b1, zsr_pkg::ADR_DELAY + 8'h04, 32'(d1));
    wb(1'b0, zsr_pkg::ADR_DELAY + 8'h04, 32'(d1));
    wb(1'b1, zsr_pkg::ADR_DELAY + 8'h1c, 32'h7ffff);
    wb(1'b0, zsr_pkg::ADR_DELAY + 8'h1c, 32'h57e40);
    fault <= 1'b1;
    cycles(6);
    chk("blocked", 1'b1, blocked_o);
    chk("active off", 1'b0, active_o);
    fault <= 1'b0;
    en    <= 1'b1;
    cycles(6);
    chk("blocked en", 1'b0, blocked_o);
    wb(1'b1, zsr_pkg::ADR_IRQ_CLR, 32'hf);
    wb(1'b1, zsr_pkg::ADR_IRQ_EN, 32'hf);
    // Blocked drops part way; the full delay must restart
    fault    <= 1'b1;
    brk_open <= 1'b1;
    cycles(9 * TICKS);
    brk_open <= 1'b0;
    cycles(6);
    chk("glitch close", 1'b0, close_o);
    chk("glitch prot", 1'b0, prot_o);
    run_seq(2);
    wb(1'b0, zsr_pkg::ADR_IRQ_STAT, 32'h3, 32'h3);
    chk("irq", 1'b1, irq);
    wb(1'b1, zsr_pkg::ADR_IRQ_CLR, 32'hf);
    cycles(2);
    chk("irq clr", 1'b0, irq);
    clear_fault();
    chk("irq idle", 1'b1, irq);
    wb(1'b1, zsr_pkg::ADR_IRQ_EN, 32'h0);
    cycles(2);
    chk("irq mask", 1'b0, irq);
    wb(1'b1, zsr_pkg::ADR_GROUP, 32'h1);
    run_seq(d1);
    clear_fault();
    for (int m = 1; m < 5; m++) begin
      wb(1'b1, zsr_pkg::ADR_CTRL, 32'(m));
      wb(1'b1, zsr_pkg::ADR_GROUP, 32'(m + 2));
      wb(1'b0, zsr_pkg::ADR_CTRL, 32'(m), 32'h7);
      fault    <= 1'b1;
      brk_open <= 1'b1;
      cycles(30 * TICKS);
      chk("mode close", 1'b0, close_o);
      wb(1'b0, zsr_pkg::ADR_STATUS, ((m == 1 || m == 3) ? 32'h80 : 32'h0) |
         ((m == 2) ? 32'h10 : 32'h0), 32'hf0);
      fault    <= 1'b0;
      brk_open <= 1'b0;
      cycles(6);
    end
    for (int f = 0; f < 5; f++) begin
      wb(1'b1, zsr_pkg::ADR_CTRL, 32'h100 | 32'(f << 12));
      cycles(2);
      wb(1'b0, zsr_pkg::ADR_STATUS, FEXP[f], 32'hf0);
    end
    wb(1'b1, zsr_pkg::ADR_CTRL, 32'h0);
    // Group switch and block command while counting, no restart
    wb(1'b1, zsr_pkg::ADR_GROUP, 32'h0);
    fault    <= 1'b1;
    brk_open <= 1'b1;
    cycles(6 * TICKS);
    wb(1'b1, zsr_pkg::ADR_GROUP, 32'h1);
    cycles(6 * TICKS);
    chk("grp close", 1'b0, close_o);
    chk("grp prot", 1'b1, prot_o);
    wb(1'b1, zsr_pkg::ADR_CTRL, 32'h10);
    cycles(2);
    chk("blk cmd", 1'b1, blocked_o);
    chk("blk idle", 1'b0, active_o);
    test_done();
  end
endmodule : tb_top
